// ==== common/eepc_pkg.sv ====
// constants, field layout and carrier types of the nonvolatile array controller
package eepc_pkg;
  // register word indices; byte address on the bus is four times the index
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_NV_DIV_HIGH = 16'hfe10;
  localparam logic [15:0] IDX_NV_DIV_LOW = 16'hfe11;
  localparam logic [15:0] IDX_DIV_HIGH = 16'hfe1a;
  localparam logic [15:0] IDX_DIV_LOW = 16'hfe1b;
  localparam logic [15:0] IDX_NV_CONFIG = 16'hfe1c;
  localparam logic [15:0] IDX_CONTROL = 16'hfe1d;
  localparam logic [15:0] IDX_SHADOW = 16'hfe1f;
  // array window: indices 0x0800..0x09ff share these upper index bits
  localparam logic [6:0] ARRAY_IDX_TOP = 7'h04;
  localparam int ARRAY_BYTES = 512;
  localparam logic [4:0] SECURE_ROW = 5'h0f;
  // latched target codes: array offsets 0..511, then the nonvolatile words
  localparam logic [9:0] TGT_NV_CONFIG = 10'h200;
  localparam logic [9:0] TGT_NV_DIV_HIGH = 10'h201;
  localparam logic [9:0] TGT_NV_DIV_LOW = 10'h202;
  // field positions
  localparam int CFG_SECURE_BIT = 4;
  localparam int DIVH_LOCK_BIT = 7;
  localparam int CTRL_LATCH_BIT = 2;
  localparam int CTRL_ENABLE_BIT = 0;
  // reset and factory values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] NV_CONFIG_FACTORY = 8'hf0;
  localparam logic [7:0] NV_DIV_FACTORY = 8'hff;
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // operation modes
  localparam logic [1:0] MODE_BYTE_PROGRAM = 2'b00;
  localparam logic [1:0] MODE_BYTE_ERASE = 2'b01;
  localparam logic [1:0] MODE_BLOCK_ERASE = 2'b10;
  localparam logic [1:0] MODE_BULK_ERASE = 2'b11;
  // timing: timebase period, and operation lengths counted in timebase ticks
  localparam int TIMEBASE_US = 35;
  localparam int MCLK_MHZ = 50;
  localparam int BUS_DIV_HINT = TIMEBASE_US * MCLK_MHZ;
  localparam int PROGRAM_TICKS = 8;
  localparam int BYTE_ERASE_TICKS = 8;
  localparam int BLOCK_ERASE_TICKS = 8;
  localparam int BULK_ERASE_TICKS = 8;
  // control register layout
  typedef struct packed {
    logic spare;
    logic zero6;
    logic power_down;
    logic [1:0] erase_mode;
    logic bus_latch_enable;
    logic auto_end;
    logic program_erase_enable;
  } eepc_ctrl_type;
endpackage : eepc_pkg

// ==== verilog/eepc_ctrl.sv ====
// program/erase control, protection and timebase of the 512-byte nonvolatile array
`timescale 1ns/1ps
// Functional notes
// - 512-byte array, internal pump, no external supply
// - reset copies nonvolatile config and divider
// - nonvolatile words programmed like array bytes
// - timebase from selectable reference through divider
// - armed security blocks array bytes 0xf0..0xff
// - armed security freezes nonvolatile config byte
// - armed security forbids block and bulk erase
// - armed: byte operations still allowed if unprotected
// - four 128-byte blocks, one protect bit each
// - protect bits apply after reset or read
// - divider lock freezes divider words and registers
// - erased bit reads one, factory 0xff, config byte 0xf0
// - program clears bits only, one byte
// - erase sets bits, byte up to array
// - selective bit programming keeps earlier cleared bits
// - auto mode timer clears enable bit
// - protected targets unaffected by program
// - mode bits encode operation, reset clears
// - enable sets only with latch and address
// - clearing enable and latch together clears enable
module eepc_ctrl
  import eepc_pkg::*;
#(
  parameter int DIV_W = 11,
  parameter int OP_CNT_W = 8,
  parameter int PROG_TICKS = PROGRAM_TICKS,
  parameter int BYTE_ERASE_TK = BYTE_ERASE_TICKS,
  parameter int BLOCK_ERASE_TK = BLOCK_ERASE_TICKS,
  parameter int BULK_ERASE_TK = BULK_ERASE_TICKS
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic FACTORY_RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMEBASE_CLOCK_SELECT,
  input wire logic CRYSTAL_REF_CLOCK,
  output logic TIMEBASE_TICK,
  output logic CHARGE_PUMP_ON,
  output logic ARRAY_POWER_DOWN
);

  // refuse shapes the logic cannot serve
  if (DIV_W < 11 || DIV_W > 16) $error("DIV_W must be 11 to 16");
  if (PROG_TICKS < 1 || BULK_ERASE_TK >= (1 << OP_CNT_W)) $error("bad tick counts");

  // array bytes plus nonvolatile words; cleared bits read 0, erased 1
  logic [7:0] mem [ARRAY_BYTES];
  logic [7:0] nv_config_byte;
  logic [7:0] nv_divider_high;
  logic [7:0] nv_divider_low;
  logic [7:0] array_config_shadow;
  logic loaded;
  logic divider_lock_arm;
  logic [DIV_W-1:0] timebase_divider;
  eepc_ctrl_type ctrl;
  eepc_ctrl_type wctl;
  logic addr_valid;
  logic [9:0] lat_tgt;
  logic [7:0] lat_data;
  logic [OP_CNT_W-1:0] op_cnt;
  logic op_fin;
  logic op_done;
  logic op_ok;
  logic [15:0] idx;
  logic acc;
  logic is_array;
  logic mapped;
  logic [9:0] req_tgt;
  logic [31:0] next_prdata;
  logic sel_s1, sel_s2, ref_s1, ref_s2, ref_s3;
  logic ref_pulse;
  logic [DIV_W-1:0] tb_cnt;
  logic [DIV_W-1:0] div_eff;
  logic [7:0] lat_byte;

  // may the latched target be changed in this mode under current protection
  function automatic logic op_permit(input logic [9:0] tgt, input logic [1:0] mode,
                                     input logic [7:0] cfg, input logic lock);
    logic armed;
    logic [1:0] blk;
    begin
      armed = ~cfg[CFG_SECURE_BIT];
      blk = tgt[8:7];
      op_permit = 1'b0;
      if (tgt == TGT_NV_CONFIG) begin
        op_permit = ~armed;
      end else if (tgt == TGT_NV_DIV_HIGH || tgt == TGT_NV_DIV_LOW) begin
        op_permit = lock;
      end else if (!tgt[9]) begin
        if (mode == MODE_BULK_ERASE) begin
          op_permit = ~armed & (cfg[3:0] == 4'h0);
        end else if (mode == MODE_BLOCK_ERASE) begin
          op_permit = ~armed & ~cfg[blk];
        end else begin
          op_permit = ~cfg[blk] & ~(armed & (tgt[8:4] == SECURE_ROW));
        end
      end
    end
  endfunction : op_permit

  // timebase ticks needed by each mode
  function automatic logic [OP_CNT_W-1:0] op_ticks(input logic [1:0] mode);
    begin
      case (mode)
        MODE_BYTE_PROGRAM: op_ticks = OP_CNT_W'(PROG_TICKS);
        MODE_BYTE_ERASE: op_ticks = OP_CNT_W'(BYTE_ERASE_TK);
        MODE_BLOCK_ERASE: op_ticks = OP_CNT_W'(BLOCK_ERASE_TK);
        default: op_ticks = OP_CNT_W'(BULK_ERASE_TK);
      endcase
    end
  endfunction : op_ticks

  // bus decode; registers sit one per word
  assign idx = PADDR[17:2];
  assign acc = PSEL & PENABLE;
  assign is_array = (idx[15:9] == ARRAY_IDX_TOP);
  assign mapped = is_array || idx == IDX_NV_DIV_HIGH || idx == IDX_NV_DIV_LOW ||
                  idx == IDX_DIV_HIGH || idx == IDX_DIV_LOW || idx == IDX_NV_CONFIG ||
                  idx == IDX_CONTROL || idx == IDX_SHADOW;
  assign PREADY = 1'b1; // zero wait states
  assign PSLVERR = acc & ~mapped;
  assign wctl = eepc_ctrl_type'(PWDATA[7:0]);
  assign op_ok = op_permit(lat_tgt, ctrl.erase_mode, array_config_shadow, divider_lock_arm);
  assign lat_byte = mem[lat_tgt[8:0]];

  // target code of the addressed nonvolatile location
  always_comb begin
    req_tgt = 10'h3ff;
    if (is_array) begin
      req_tgt = {1'b0, idx[8:0]};
    end else if (idx == IDX_NV_CONFIG) begin
      req_tgt = TGT_NV_CONFIG;
    end else if (idx == IDX_NV_DIV_HIGH) begin
      req_tgt = TGT_NV_DIV_HIGH;
    end else if (idx == IDX_NV_DIV_LOW) begin
      req_tgt = TGT_NV_DIV_LOW;
    end
  end

  // read data, captured in the setup cycle so it stands through the access
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (is_array) begin
      next_prdata[7:0] = mem[idx[8:0]];
    end else begin
      case (idx)
        IDX_NV_DIV_HIGH: next_prdata[7:0] = nv_divider_high;
        IDX_NV_DIV_LOW: next_prdata[7:0] = nv_divider_low;
        IDX_DIV_HIGH: next_prdata[7:0] = {divider_lock_arm, 4'h0, timebase_divider[10:8]};
        IDX_DIV_LOW: next_prdata[7:0] = timebase_divider[7:0];
        IDX_NV_CONFIG: next_prdata[7:0] = nv_config_byte;
        IDX_CONTROL: next_prdata[7:0] = ctrl;
        IDX_SHADOW: next_prdata[7:0] = array_config_shadow;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_prdata;
    end
  end

  // reset copies nonvolatile settings into the volatile registers at release
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      loaded <= 1'b0;
      array_config_shadow <= SHADOW_RESET;
    end else if (!loaded) begin
      loaded <= 1'b1;
      array_config_shadow <= nv_config_byte;
    end else if (acc && !PWRITE && idx == IDX_NV_CONFIG) begin
      array_config_shadow[3:0] <= nv_config_byte[3:0];
    end
  end

  // divider registers: loaded at release, writable only while unlocked
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      divider_lock_arm <= 1'b0;
      timebase_divider <= '0;
    end else if (!loaded) begin
      divider_lock_arm <= nv_divider_high[DIVH_LOCK_BIT];
      timebase_divider <= DIV_W'({nv_divider_high[2:0], nv_divider_low});
    end else if (acc && PWRITE && divider_lock_arm) begin
      if (idx == IDX_DIV_HIGH) begin
        divider_lock_arm <= PWDATA[DIVH_LOCK_BIT];
        timebase_divider[10:8] <= PWDATA[2:0];
      end else if (idx == IDX_DIV_LOW) begin
        timebase_divider[7:0] <= PWDATA[7:0];
      end
    end
  end

  // control register with its guarded enable and latch bits
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= eepc_ctrl_type'(CTRL_RESET);
    end else if (acc && PWRITE && idx == IDX_CONTROL) begin
      ctrl.spare <= wctl.spare;
      ctrl.zero6 <= 1'b0;
      ctrl.power_down <= wctl.power_down;
      ctrl.auto_end <= wctl.auto_end;
      if (!ctrl.program_erase_enable) begin
        ctrl.erase_mode <= wctl.erase_mode; // frozen while an operation runs
      end
      ctrl.program_erase_enable <= wctl.program_erase_enable &
                                   ctrl.bus_latch_enable & addr_valid;
      ctrl.bus_latch_enable <= wctl.bus_latch_enable |
                               ctrl.program_erase_enable;
    end else if (op_done && ctrl.auto_end) begin
      ctrl.program_erase_enable <= 1'b0;
    end
  end

  // address and data latch for the next operation; the last valid write wins
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_valid <= 1'b0;
      lat_tgt <= 10'h000;
      lat_data <= ERASED_BYTE;
    end else if (!ctrl.bus_latch_enable) begin
      addr_valid <= 1'b0;
    end else if (acc && PWRITE && !req_tgt[9] | (req_tgt[9:2] == 8'h80) &&
                 !ctrl.program_erase_enable && req_tgt != 10'h203) begin
      addr_valid <= 1'b1;
      lat_tgt <= req_tgt;
      lat_data <= PWDATA[7:0];
    end
  end

  // pin inputs pass two flip-flops; a third stage finds crystal rising edges
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      sel_s1 <= TIMEBASE_CLOCK_SELECT;
      sel_s2 <= sel_s1;
      ref_s1 <= CRYSTAL_REF_CLOCK;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  // one reference cycle is a bus cycle or a crystal rising edge
  assign ref_pulse = sel_s2 ? (ref_s2 & ~ref_s3) : 1'b1;
  assign div_eff = (timebase_divider == '0) ? DIV_W'(1) : timebase_divider;

  // timebase divider: one tick per divider count of reference cycles
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tb_cnt <= '0;
      TIMEBASE_TICK <= 1'b0;
    end else if (ref_pulse && tb_cnt >= div_eff - DIV_W'(1)) begin
      tb_cnt <= '0;
      TIMEBASE_TICK <= 1'b1;
    end else begin
      tb_cnt <= ref_pulse ? tb_cnt + DIV_W'(1) : tb_cnt;
      TIMEBASE_TICK <= 1'b0;
    end
  end

  // operation timer counted in timebase ticks; done pulses once per operation
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      op_cnt <= '0;
      op_fin <= 1'b0;
      op_done <= 1'b0;
    end else if (!ctrl.program_erase_enable) begin
      op_cnt <= '0;
      op_fin <= 1'b0;
      op_done <= 1'b0;
    end else if (TIMEBASE_TICK && !op_fin) begin
      op_cnt <= op_cnt + OP_CNT_W'(1);
      op_fin <= (op_cnt + OP_CNT_W'(1) == op_ticks(ctrl.erase_mode));
      op_done <= (op_cnt + OP_CNT_W'(1) == op_ticks(ctrl.erase_mode));
    end else begin
      op_done <= 1'b0;
    end
  end

  // pump and power status pins
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      CHARGE_PUMP_ON <= 1'b0;
      ARRAY_POWER_DOWN <= 1'b0;
    end else begin
      CHARGE_PUMP_ON <= ctrl.program_erase_enable & ~op_fin;
      ARRAY_POWER_DOWN <= ctrl.power_down;
    end
  end

  // nonvolatile storage: kept over system reset, factory state on its own reset
  always_ff @(posedge MCLK or negedge FACTORY_RSTN) begin
    if (!FACTORY_RSTN) begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
      nv_config_byte <= NV_CONFIG_FACTORY;
      nv_divider_high <= NV_DIV_FACTORY;
      nv_divider_low <= NV_DIV_FACTORY;
    end else if (op_done && op_ok) begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        if (!lat_tgt[9]) begin
          case (ctrl.erase_mode)
            MODE_BYTE_PROGRAM: if (lat_tgt[8:0] == 9'(i)) mem[i] <= mem[i] & lat_data;
            MODE_BYTE_ERASE: if (lat_tgt[8:0] == 9'(i)) mem[i] <= ERASED_BYTE;
            MODE_BLOCK_ERASE: if (lat_tgt[8:7] == 2'(i / 128)) mem[i] <= ERASED_BYTE;
            default: mem[i] <= ERASED_BYTE;
          endcase
        end
      end
      if (lat_tgt == TGT_NV_CONFIG) begin
        nv_config_byte <= (ctrl.erase_mode == MODE_BYTE_PROGRAM) ?
                          (nv_config_byte & lat_data) : ERASED_BYTE;
      end
      if (lat_tgt == TGT_NV_DIV_HIGH) begin
        nv_divider_high <= (ctrl.erase_mode == MODE_BYTE_PROGRAM) ?
                           (nv_divider_high & lat_data) : ERASED_BYTE;
      end
      if (lat_tgt == TGT_NV_DIV_LOW) begin
        nv_divider_low <= (ctrl.erase_mode == MODE_BYTE_PROGRAM) ?
                          (nv_divider_low & lat_data) : ERASED_BYTE;
      end
    end
  end

  // checks on the logic above
  property p_load_cfg;
    @(posedge MCLK) disable iff (!RSTN) loaded && !$past(loaded) |->
      array_config_shadow == $past(nv_config_byte);
  endproperty
  a_load_cfg: assert property (p_load_cfg) else $error("shadow not loaded at release");

  property p_pgm_gate;
    @(posedge MCLK) disable iff (!RSTN) $rose(ctrl.program_erase_enable) |->
      $past(ctrl.bus_latch_enable) && $past(addr_valid);
  endproperty
  a_pgm_gate: assert property (p_pgm_gate) else $error("enable set without latch");

  property p_latch_kept;
    @(posedge MCLK) disable iff (!RSTN)
      ctrl.program_erase_enable && acc && PWRITE && idx == IDX_CONTROL |=>
      ctrl.bus_latch_enable && !ctrl.program_erase_enable == !$past(PWDATA[CTRL_ENABLE_BIT] &&
      ctrl.bus_latch_enable);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch cleared with enable");

  property p_auto_end;
    @(posedge MCLK) disable iff (!RSTN)
      op_done && ctrl.auto_end && !(acc && PWRITE && idx == IDX_CONTROL) |=>
      !ctrl.program_erase_enable ##1 !op_done;
  endproperty
  a_auto_end: assert property (p_auto_end) else $error("auto mode left enable set");

  property p_prog_and;
    @(posedge MCLK) disable iff (!RSTN)
      op_done && op_ok && !lat_tgt[9] && ctrl.erase_mode == MODE_BYTE_PROGRAM |=>
      lat_byte == ($past(lat_byte) & lat_data);
  endproperty
  a_prog_and: assert property (p_prog_and) else $error("program did not clear bits");

  property p_denied;
    @(posedge MCLK) disable iff (!RSTN) op_done && !op_ok && !lat_tgt[9] |=> $stable(lat_byte);
  endproperty
  a_denied: assert property (p_denied) else $error("protected byte changed");

  property p_secure;
    @(posedge MCLK) disable iff (!RSTN)
      loaded && !array_config_shadow[CFG_SECURE_BIT] &&
      (ctrl.erase_mode[1] || (!lat_tgt[9] && lat_tgt[8:4] == SECURE_ROW) ||
      lat_tgt == TGT_NV_CONFIG) |-> !op_ok;
  endproperty
  a_secure: assert property (p_secure) else $error("secured operation allowed");

  property p_div_lock;
    @(posedge MCLK) disable iff (!RSTN) loaded && !divider_lock_arm |=>
      !divider_lock_arm && $stable(timebase_divider);
  endproperty
  a_div_lock: assert property (p_div_lock) else $error("locked divider changed");

  property p_tick_gap;
    @(posedge MCLK) disable iff (!RSTN)
      TIMEBASE_TICK && !sel_s2 && div_eff == DIV_W'(2) ##1 !sel_s2 ##1 !sel_s2 |->
      TIMEBASE_TICK && !$past(TIMEBASE_TICK);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");

endmodule : eepc_ctrl

// ==== dv/tb.sv ====
// self-checking testbench of the nonvolatile array program/erase controller
`timescale 1ns/1ps
module tb;
  import eepc_pkg::*;
  typedef struct {
    logic [1:0] mode;
    logic [15:0] idx;
    logic [7:0] data;
    logic [15:0] cidx;
    logic [7:0] exp;
  } eepc_row_type;
  logic MCLK, RSTN, FACTORY_RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic TIMEBASE_CLOCK_SELECT, CRYSTAL_REF_CLOCK, TIMEBASE_TICK, CHARGE_PUMP_ON, ARRAY_POWER_DOWN;
  int miscompares = 0;
  int check_count = 0;
  int gap;
  logic [7:0] rd;
  logic err;
  eepc_row_type rows [10];

  // short operation counts keep every program/erase to a few timebase ticks
  eepc_ctrl #(.PROG_TICKS(2), .BYTE_ERASE_TK(2), .BLOCK_ERASE_TK(2), .BULK_ERASE_TK(2)) eepc_ctrl_i (
    .MCLK(MCLK), .RSTN(RSTN), .FACTORY_RSTN(FACTORY_RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TIMEBASE_CLOCK_SELECT(TIMEBASE_CLOCK_SELECT),
    .CRYSTAL_REF_CLOCK(CRYSTAL_REF_CLOCK), .TIMEBASE_TICK(TIMEBASE_TICK),
    .CHARGE_PUMP_ON(CHARGE_PUMP_ON), .ARRAY_POWER_DOWN(ARRAY_POWER_DOWN));

  // bus clock, 20 ns period
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // crystal reference, eight bus periods long, offset in phase
  initial begin
    CRYSTAL_REF_CLOCK = 1'b0;
    #7;
    forever #80 CRYSTAL_REF_CLOCK = ~CRYSTAL_REF_CLOCK;
  end

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task timeout();
    miscompares++;
    $display("ERROR wait_limit expected response seen none");
    finish_test();
  endtask : timeout

  // one bus transfer: setup cycle, access until ready, then one idle edge
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h000000, wd};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) timeout();
    rd = PRDATA[7:0];
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : apb

  task rdchk(input string name, input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, rd, exp);
  endtask : rdchk

  // full auto-terminated operation: latch, target write, enable, poll, unlatch
  task op(input logic [1:0] mode, input logic [15:0] idx, input logic [7:0] d);
    int n;
    apb(1'b1, IDX_CONTROL, {3'b000, mode, 3'b110});
    apb(1'b1, idx, d);
    apb(1'b1, IDX_CONTROL, {3'b000, mode, 3'b111});
    n = 0;
    do begin
      apb(1'b0, IDX_CONTROL, 8'h00);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    if (rd[0] !== 1'b0) timeout();
    apb(1'b1, IDX_CONTROL, 8'h00);
  endtask : op

  // bus cycles between two timebase ticks
  task tick_gap();
    int n;
    n = 0;
    @(posedge MCLK);
    while (TIMEBASE_TICK !== 1'b1 && n < 100) begin
      @(posedge MCLK);
      n++;
    end
    gap = 0;
    do begin
      @(posedge MCLK);
      gap++;
    end while (TIMEBASE_TICK !== 1'b1 && gap < 100);
    if (TIMEBASE_TICK !== 1'b1) timeout();
  endtask : tick_gap

  task do_reset(input logic factory);
    RSTN <= 1'b0;
    FACTORY_RSTN <= ~factory;
    repeat (6) @(posedge MCLK);
    RSTN <= 1'b1;
    FACTORY_RSTN <= 1'b1;
    repeat (2) @(posedge MCLK);
  endtask : do_reset

  // main sequence
  initial begin
    RSTN = 1'b0;
    FACTORY_RSTN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = 32'h00000000;
    TIMEBASE_CLOCK_SELECT = 1'b0;
    rows = '{
      '{MODE_BYTE_PROGRAM, 16'h0800, 8'hfe, 16'h0800, 8'hfe},
      '{MODE_BYTE_PROGRAM, 16'h0800, 8'hfd, 16'h0800, 8'hfc},
      '{MODE_BYTE_PROGRAM, 16'h09ff, 8'h5a, 16'h09ff, 8'h5a},
      '{MODE_BYTE_ERASE, 16'h0800, 8'h00, 16'h0800, 8'hff},
      '{MODE_BYTE_PROGRAM, 16'h0900, 8'h00, 16'h0900, 8'h00},
      '{MODE_BYTE_PROGRAM, 16'h097f, 8'h0f, 16'h097f, 8'h0f},
      '{MODE_BLOCK_ERASE, 16'h0950, 8'h00, 16'h0900, 8'hff},
      '{MODE_BYTE_PROGRAM, 16'h09fe, 8'hff, 16'h097f, 8'hff},
      '{MODE_BYTE_PROGRAM, 16'h0880, 8'hff, 16'h09ff, 8'h5a},
      '{MODE_BULK_ERASE, 16'h0800, 8'h00, 16'h09ff, 8'hff}};
    @(posedge MCLK);
    do_reset(1'b1);
    // values copied in at reset, factory storage
    rdchk("control", IDX_CONTROL, 8'h00);
    rdchk("shadow", IDX_SHADOW, 8'hf0);
    rdchk("div_high", IDX_DIV_HIGH, 8'h87);
    rdchk("div_low", IDX_DIV_LOW, 8'hff);
    rdchk("array_lo", 16'h0800, ERASED_BYTE);
    rdchk("array_hi", 16'h09ff, ERASED_BYTE);
    $display("test reset done");
    // enable refused without latch or latched address, then joint clear
    apb(1'b1, IDX_CONTROL, 8'h01);
    rdchk("enable_nolatch", IDX_CONTROL, 8'h00);
    apb(1'b1, IDX_CONTROL, 8'h04);
    apb(1'b1, IDX_CONTROL, 8'h05);
    rdchk("enable_noaddr", IDX_CONTROL, 8'h04);
    apb(1'b1, 16'h0810, 8'h00);
    apb(1'b1, IDX_CONTROL, 8'h05);
    @(posedge MCLK);
    chk("pump_on", {7'h00, CHARGE_PUMP_ON}, 8'h01);
    rdchk("enable_set", IDX_CONTROL, 8'h05);
    apb(1'b1, IDX_CONTROL, 8'h00);
    rdchk("joint_clear", IDX_CONTROL, 8'h04);
    apb(1'b1, IDX_CONTROL, 8'h00);
    rdchk("latch_clear", IDX_CONTROL, 8'h00);
    rdchk("early_stop", 16'h0810, 8'hff);
    $display("test enable done");
    // power down bit, spare bit, constant bit, unmapped access
    apb(1'b1, IDX_CONTROL, 8'he0);
    @(posedge MCLK);
    chk("power_down", {7'h00, ARRAY_POWER_DOWN}, 8'h01);
    rdchk("ctrl_bits", IDX_CONTROL, 8'ha0);
    chk("slverr_ok", {7'h00, err}, 8'h00);
    apb(1'b1, IDX_CONTROL, 8'h00);
    apb(1'b0, 16'hfe1e, 8'h00);
    chk("slverr_bad", {7'h00, err}, 8'h01);
    $display("test control done");
    // timebase from bus clock, then from the crystal reference
    apb(1'b1, IDX_DIV_HIGH, 8'h80);
    apb(1'b1, IDX_DIV_LOW, 8'h02);
    rdchk("div_high_wr", IDX_DIV_HIGH, 8'h80);
    rdchk("div_low_wr", IDX_DIV_LOW, 8'h02);
    tick_gap();
    chk("tick_bus", 8'(gap), 8'h02);
    TIMEBASE_CLOCK_SELECT <= 1'b1;
    repeat (40) @(posedge MCLK);
    tick_gap();
    chk("tick_xtal", 8'(gap), 8'h10);
    TIMEBASE_CLOCK_SELECT <= 1'b0;
    repeat (40) @(posedge MCLK);
    $display("test timebase done");
    // ordinary operations, every mode
    foreach (rows[i]) begin
      op(rows[i].mode, rows[i].idx, rows[i].data);
      rdchk("row", rows[i].cidx, rows[i].exp);
    end
    $display("test rows done");
    // block protect takes effect only after the nonvolatile byte is read
    op(MODE_BYTE_ERASE, IDX_NV_CONFIG, 8'h00);
    rdchk("shadow_stale", IDX_SHADOW, 8'hf0);
    op(MODE_BYTE_PROGRAM, 16'h0880, 8'h00);
    rdchk("before_load", 16'h0880, 8'h00);
    rdchk("nv_erased", IDX_NV_CONFIG, 8'hff);
    rdchk("shadow_load", IDX_SHADOW, 8'hff);
    op(MODE_BYTE_PROGRAM, 16'h0881, 8'h00);
    rdchk("protected", 16'h0881, 8'hff);
    op(MODE_BYTE_ERASE, 16'h0880, 8'h00);
    rdchk("prot_erase", 16'h0880, 8'h00);
    op(MODE_BYTE_PROGRAM, IDX_NV_CONFIG, 8'he0);
    rdchk("nv_armed", IDX_NV_CONFIG, 8'he0);
    op(MODE_BYTE_PROGRAM, IDX_NV_DIV_HIGH, 8'h78);
    op(MODE_BYTE_PROGRAM, IDX_NV_DIV_LOW, 8'h02);
    rdchk("nv_div_low", IDX_NV_DIV_LOW, 8'h02);
    $display("test protect done");
    // armed security and divider lock after a system reset
    do_reset(1'b0);
    rdchk("shadow_arm", IDX_SHADOW, 8'he0);
    rdchk("div_high_lk", IDX_DIV_HIGH, 8'h00);
    rdchk("div_low_lk", IDX_DIV_LOW, 8'h02);
    apb(1'b1, IDX_DIV_LOW, 8'h05);
    rdchk("div_frozen", IDX_DIV_LOW, 8'h02);
    op(MODE_BYTE_PROGRAM, IDX_NV_DIV_LOW, 8'h00);
    rdchk("nv_div_frozen", IDX_NV_DIV_LOW, 8'h02);
    op(MODE_BYTE_PROGRAM, 16'h08f0, 8'h00);
    rdchk("secure_row", 16'h08f0, 8'hff);
    op(MODE_BYTE_PROGRAM, 16'h0800, 8'h00);
    rdchk("armed_prog", 16'h0800, 8'h00);
    op(MODE_BULK_ERASE, 16'h0900, 8'h00);
    rdchk("armed_bulk", 16'h0800, 8'h00);
    op(MODE_BLOCK_ERASE, 16'h0800, 8'h00);
    rdchk("armed_block", 16'h0800, 8'h00);
    op(MODE_BYTE_ERASE, 16'h0800, 8'h00);
    rdchk("armed_erase", 16'h0800, 8'hff);
    op(MODE_BYTE_ERASE, IDX_NV_CONFIG, 8'h00);
    rdchk("nv_frozen", IDX_NV_CONFIG, 8'he0);
    $display("test armed done");
    finish_test();
  end
endmodule : tb
